// [rtl/ppp_pkg.sv]
// Behaviour
// (R1) Fuse bits read zero when programmed and one when unprogrammed.
// (R2) Extended fuse bits 7:3 unused and one; bits 2:0 brown-out level, default one.
// (R3) High fuse layout: debug 7, scan 6, serial 5, watchdog 4, preserve 3, boot 2:1, vector 0.
// (R4) High fuse default: scan, serial and boot size programmed; all others unprogrammed.
// (R5) Low fuse: div8 bit7, clock out bit6, start-up 5:4, clock source 3:0.
// (R6) Default clock source selects the internal RC oscillator at 8 MHz.
// (R7) Serial download fuse is neither read nor written in serial programming mode.
// (R8) Chip erase leaves every fuse bit unchanged.
// (R9) Programmed first lock bit blocks any fuse change.
// (R10) Fuses latch on programming entry and power-up; changes act after programming exit.
// (R11) EEPROM-preserve fuse acts at once when programmed.
// (R12) Three-byte identity at signature addresses 0 to 2, readable even when locked.
// (R13) Calibration byte sits in signature high byte 0; copied to calibration register on reset.
// (R14) Flash: 256 pages of 128 words; word from PC[6:0], page from PC[14:7].
// (R15) EEPROM: 256 pages of 8 bytes; byte from address[2:0], page from [10:3].
// (R16) Programmer holds every strobe at least 250 ns; the model holds output enable low only 3 cycles (120 ns).
// (R17) Ready/busy is low while programming, high when ready for a command.
// (R18) Data bus driven by device only while output enable is low; the port registers data_oe, which follows oe_n one cycle late.
// (R19) Crystal strobe rising: action 00 address, 01 data, 10 command, 11 nothing.
// (R20) Byte selects choose address, flash data or fuse byte as encoded.
// (R21) Write or output-enable strobe performs the last loaded command.
// (R22) Programming entry needs page-load, both action selects and byte select low.
// (R23) Command bytes decode to erase, fuse, lock, flash, EEPROM writes and reads.
// (R24) Programmer waits 100 ns and 50 us around entry before commands.
// (R25) Page-load rising latches loaded data into the page buffer at the low address.
// (R26) Write strobe under write flash programs the page and holds busy until done.
// (R27) Reserved byte-select codes are ignored, nothing stored changes.
package ppp_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_MIN_NS = 250;
  localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS = 4000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_OSC_HZ = 8000000;

  // fuse field positions
  localparam int EFB_BOD_LSB = 0;
  localparam int EFB_BOD_W = 3;
  localparam int HFB_DEBUG_EN = 7;
  localparam int HFB_SCAN_EN = 6;
  localparam int HFB_SERIAL_DL_EN = 5;
  localparam int HFB_WDT_ON = 4;
  localparam int HFB_EE_PRESERVE = 3;
  localparam int HFB_BOOT_SIZE_LSB = 1;
  localparam int HFB_RST_VECTOR = 0;
  localparam int LFB_CLK_DIV8 = 7;
  localparam int LFB_CLK_OUT = 6;
  localparam int LFB_SUT_LSB = 4;
  localparam int LFB_CKSEL_LSB = 0;
  localparam int LOCK_LB1_BIT = 0;

  localparam logic [7:0] EXT_FUSE_RESET = 8'hFF;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hF8;
  localparam logic [7:0] HIGH_FUSE_RESET = 8'h99;
  localparam logic [7:0] LOW_FUSE_RESET = 8'h62;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [3:0] CKSEL_INT_RC = 4'h2;
  localparam logic [7:0] CAL_BYTE_RESET = 8'h80;

  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_SIG = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_READ_EEPROM = 8'h03;
  localparam logic [7:0] CMD_NOP = 8'h00;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] BSEL_LOW = 2'h0;
  localparam logic [1:0] BSEL_HIGH = 2'h1;
  localparam logic [1:0] BSEL_EXT = 2'h2;
  localparam logic [1:0] BSEL_FHIGH = 2'h3;

  localparam int FLASH_WORD_BITS = 7;
  localparam int FLASH_PAGE_BITS = 8;
  localparam int FLASH_ADDR_TOP = 14;
  localparam int EE_BYTE_BITS = 3;
  localparam int EE_PAGE_BITS = 8;
  localparam int EEPROM_ADDR_TOP = 10;
  localparam logic [7:0] SIG_ADDR_LAST = 8'h02;

  typedef enum logic [1:0] {
    PPP_IDLE = 2'b01,
    PPP_BUSY = 2'b10
  } ppp_busy_state_t;
endpackage : ppp_pkg

// [rtl/ppp_busy_timer.sv]
`timescale 1ns/10ps
module ppp_busy_timer #(
  parameter int CYCLES = ppp_pkg::PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  output logic ready_q
);
  import ppp_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  ppp_busy_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ready_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      PPP_IDLE: begin
        if (start) begin
          state_d = PPP_BUSY;
          cnt_d = CW'(CYCLES - 1);
        end
      end
      PPP_BUSY: begin
        if (cnt_q == '0) begin
          state_d = PPP_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = PPP_IDLE;
      end
    endcase
    ready_d = (state_d == PPP_IDLE); // R17
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= PPP_IDLE;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end
endmodule : ppp_busy_timer

// [rtl/ppp_program_port.sv]
`timescale 1ns/10ps
module ppp_program_port #(
  parameter int FWB = ppp_pkg::FLASH_WORD_BITS,
  parameter int FPB = ppp_pkg::FLASH_PAGE_BITS,
  parameter int EBB = ppp_pkg::EE_BYTE_BITS,
  parameter int EPB = ppp_pkg::EE_PAGE_BITS,
  parameter int BUSY_CYCLES = ppp_pkg::PROG_CYCLES,
  // identity bytes: values are arbitrary
  parameter logic [7:0] SIG_BYTE0 = 8'hA5,
  parameter logic [7:0] SIG_BYTE1 = 8'h5A,
  parameter logic [7:0] SIG_BYTE2 = 8'h3C,
  parameter logic [7:0] CAL_BYTE = ppp_pkg::CAL_BYTE_RESET
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hv_reset_in,
  input wire logic serial_prog_mode,
  input wire logic crystal_in_strobe,
  input wire logic strobe_action_sel_0,
  input wire logic strobe_action_sel_1,
  input wire logic byte_select_lo,
  input wire logic byte_select_hi,
  input wire logic page_load_strobe,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_out,
  output logic prog_active,
  output logic [7:0] ext_fuse_latched,
  output logic [7:0] high_fuse_latched,
  output logic [7:0] low_fuse_latched,
  output logic eeprom_preserve_active,
  output logic int_rc_osc_sel,
  output logic [7:0] osc_calibration_reg
);
  import ppp_pkg::*;
  localparam int FLASH_WORDS = 1 << (FWB + FPB);
  localparam int EE_BYTES = 1 << (EBB + EPB);
  localparam int FAW = FWB + FPB;
  localparam int EAW = EBB + EPB;
  localparam logic [7:0] SERIAL_DL_MASK = 8'h01 << HFB_SERIAL_DL_EN;

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] flash_buf [1 << FWB];
  logic [7:0] ee_buf [1 << EBB];

  logic xtal_prev_q;
  logic page_load_strobe_prev_q;
  logic wr_n_prev_q;
  logic hv_prev_q;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_lo_d;
  logic [7:0] addr_hi_q;
  logic [7:0] addr_hi_d;
  logic [7:0] addr_ext_q;
  logic [7:0] addr_ext_d;
  logic [7:0] dat_lo_q;
  logic [7:0] dat_lo_d;
  logic [7:0] dat_hi_q;
  logic [7:0] dat_hi_d;
  logic [7:0] efuse_q;
  logic [7:0] efuse_d;
  logic [7:0] hfuse_q;
  logic [7:0] hfuse_d;
  logic [7:0] lfuse_q;
  logic [7:0] lfuse_d;
  logic [7:0] lock_q;
  logic [7:0] lock_d;
  logic [7:0] ext_lat_d;
  logic [7:0] high_lat_d;
  logic [7:0] low_lat_d;
  logic prog_d;
  logic ready;
  logic wr_start;
  logic xtal_rise;
  logic page_load_strobe_rise;
  logic wr_fall;
  logic hv_rise;
  logic hv_fall;
  logic [1:0] act;
  logic [1:0] bsel;
  logic [FAW-1:0] flash_word;
  logic [EAW-1:0] ee_addr;
  logic [7:0] rd_byte;
  logic [7:0] data_out_d;
  logic [15:0] fword;

  function automatic logic [7:0] ppp_fuse_write(input logic [7:0] cur, input logic [7:0] val,
                                                input logic [7:0] keep);
    ppp_fuse_write = (cur & keep) | (val & ~keep);
  endfunction : ppp_fuse_write

  // only these commands start an internal operation; all others are read or no-op
  function automatic logic ppp_is_write_cmd(input logic [7:0] c);
    ppp_is_write_cmd = (c == CMD_CHIP_ERASE) || (c == CMD_WRITE_FUSE) ||
                       (c == CMD_WRITE_LOCK) || (c == CMD_WRITE_FLASH) ||
                       (c == CMD_WRITE_EEPROM);
  endfunction : ppp_is_write_cmd

  assign act = {strobe_action_sel_1, strobe_action_sel_0};
  assign bsel = {byte_select_hi, byte_select_lo};
  // inputs are synchronous, so one register per strobe is enough for edges
  assign xtal_rise = crystal_in_strobe & ~xtal_prev_q & prog_active;
  assign page_load_strobe_rise = page_load_strobe & ~page_load_strobe_prev_q & prog_active;
  assign wr_fall = ~wr_n & wr_n_prev_q & prog_active;
  assign hv_rise = hv_reset_in & ~hv_prev_q;
  assign hv_fall = ~hv_reset_in & hv_prev_q;
  // write strobes arriving while busy are dropped; the programmer must wait for ready
  assign wr_start = wr_fall & ready & ppp_is_write_cmd(cmd_q); // R21 R23
  assign flash_word = FAW'({addr_hi_q, addr_lo_q}); // R14
  assign ee_addr = EAW'({addr_hi_q, addr_lo_q}); // R15
  assign fword = flash_mem[flash_word];

  always_comb begin
    cmd_d = cmd_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    addr_ext_d = addr_ext_q;
    dat_lo_d = dat_lo_q;
    dat_hi_d = dat_hi_q;
    efuse_d = efuse_q;
    hfuse_d = hfuse_q;
    lfuse_d = lfuse_q;
    lock_d = lock_q;
    ext_lat_d = ext_fuse_latched;
    high_lat_d = high_fuse_latched;
    low_lat_d = low_fuse_latched;
    prog_d = prog_active;
    if (hv_rise && !page_load_strobe && act == ACT_ADDR && !byte_select_lo) begin
      prog_d = 1'b1; // R22
    end else if (hv_fall) begin
      prog_d = 1'b0;
    end
    if ((hv_rise && prog_d) || (hv_fall && prog_active)) begin
      ext_lat_d = efuse_q; // R10
      high_lat_d = hfuse_q; // R10
      low_lat_d = lfuse_q; // R10
    end
    if (xtal_rise) begin
      unique case (act) // R19
        ACT_ADDR: begin
          unique case (bsel) // R20
            BSEL_LOW: addr_lo_d = data_in;
            BSEL_HIGH: addr_hi_d = data_in;
            BSEL_EXT: addr_ext_d = data_in;
            BSEL_FHIGH: ; // R27
          endcase
        end
        ACT_DATA: begin
          if (!byte_select_hi) begin // R27
            if (byte_select_lo) begin
              dat_hi_d = data_in; // R20
            end else begin
              dat_lo_d = data_in;
            end
          end
        end
        ACT_CMD: cmd_d = data_in;
        default: ;
      endcase
    end
    if (wr_start) begin
      if (cmd_q == CMD_CHIP_ERASE) begin
        lock_d = LOCK_RESET; // R8
      end else if (cmd_q == CMD_WRITE_LOCK) begin
        lock_d = lock_q & data_in;
      end else if (cmd_q == CMD_WRITE_FUSE && lock_q[LOCK_LB1_BIT]) begin // R9
        unique case (bsel) // R20
          BSEL_LOW: lfuse_d = data_in; // R5
          BSEL_HIGH: hfuse_d = ppp_fuse_write(hfuse_q, data_in,
                               serial_prog_mode ? SERIAL_DL_MASK : 8'h00); // R7 R3
          BSEL_EXT: efuse_d = data_in | EXT_UNUSED_MASK; // R2
          BSEL_FHIGH: ; // R27
        endcase
      end
    end
  end

  always_comb begin
    rd_byte = 8'hFF;
    unique case (cmd_q)
      CMD_READ_SIG: begin
        if (byte_select_lo) begin
          rd_byte = (addr_lo_q == 8'h00) ? CAL_BYTE : 8'hFF; // R13
        end else if (addr_lo_q <= SIG_ADDR_LAST) begin
          rd_byte = (addr_lo_q == 8'h00) ? SIG_BYTE0 :
                    (addr_lo_q == 8'h01) ? SIG_BYTE1 : SIG_BYTE2; // R12
        end
      end
      CMD_READ_FUSE: begin
        unique case (bsel) // R20
          BSEL_LOW: rd_byte = lfuse_q; // R1
          BSEL_HIGH: rd_byte = lock_q;
          BSEL_EXT: rd_byte = efuse_q;
          BSEL_FHIGH: rd_byte = serial_prog_mode ? (hfuse_q | SERIAL_DL_MASK) : hfuse_q; // R7
        endcase
      end
      CMD_READ_FLASH: rd_byte = byte_select_lo ? fword[15:8] : fword[7:0];
      CMD_READ_EEPROM: rd_byte = ee_mem[ee_addr];
      default: rd_byte = 8'hFF;
    endcase
    data_out_d = rd_byte;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xtal_prev_q <= 1'b0;
      page_load_strobe_prev_q <= 1'b0;
      wr_n_prev_q <= 1'b1;
      hv_prev_q <= 1'b0;
      cmd_q <= CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      addr_ext_q <= 8'h00;
      dat_lo_q <= 8'hFF;
      dat_hi_q <= 8'hFF;
      efuse_q <= EXT_FUSE_RESET; // R2
      hfuse_q <= HIGH_FUSE_RESET; // R4
      lfuse_q <= LOW_FUSE_RESET; // R5
      lock_q <= LOCK_RESET;
      ext_fuse_latched <= EXT_FUSE_RESET; // R10
      high_fuse_latched <= HIGH_FUSE_RESET; // R10
      low_fuse_latched <= LOW_FUSE_RESET; // R10
      prog_active <= 1'b0;
      data_out <= 8'hFF;
      data_oe <= 1'b0;
      eeprom_preserve_active <= 1'b0;
      int_rc_osc_sel <= 1'b1;
      osc_calibration_reg <= CAL_BYTE; // R13
    end else begin
      xtal_prev_q <= crystal_in_strobe;
      page_load_strobe_prev_q <= page_load_strobe;
      wr_n_prev_q <= wr_n;
      hv_prev_q <= hv_reset_in;
      cmd_q <= cmd_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      addr_ext_q <= addr_ext_d;
      dat_lo_q <= dat_lo_d;
      dat_hi_q <= dat_hi_d;
      efuse_q <= efuse_d;
      hfuse_q <= hfuse_d;
      lfuse_q <= lfuse_d;
      lock_q <= lock_d;
      ext_fuse_latched <= ext_lat_d;
      high_fuse_latched <= high_lat_d;
      low_fuse_latched <= low_lat_d;
      prog_active <= prog_d;
      data_out <= data_out_d;
      data_oe <= prog_d & ~oe_n; // R18
      // preserve is programmed (zero) as soon as either the cell or the latch says so
      eeprom_preserve_active <= ~(hfuse_d[HFB_EE_PRESERVE] & high_lat_d[HFB_EE_PRESERVE]); // R11
      int_rc_osc_sel <= (low_lat_d[LFB_CKSEL_LSB +: 4] == CKSEL_INT_RC); // R6
      osc_calibration_reg <= osc_calibration_reg;
    end
  end

  // arrays carry no reset: they stand for nonvolatile cells and page latches
  always_ff @(posedge mclk) begin
    if (page_load_strobe_rise) begin
      if (cmd_q == CMD_WRITE_EEPROM) begin
        ee_buf[addr_lo_q[EBB-1:0]] <= dat_lo_q; // R25 R15
      end else begin
        flash_buf[addr_lo_q[FWB-1:0]] <= {dat_hi_q, dat_lo_q}; // R25 R14
      end
    end
    // a page write copies the whole buffer: words never loaded keep stale latch contents
    if (wr_start && cmd_q == CMD_WRITE_FLASH) begin
      for (int i = 0; i < (1 << FWB); i++) begin
        flash_mem[{flash_word[FAW-1:FWB], FWB'(i)}] <= flash_buf[i]; // R26
      end
    end
    if (wr_start && cmd_q == CMD_WRITE_EEPROM) begin
      for (int i = 0; i < (1 << EBB); i++) begin
        ee_mem[{ee_addr[EAW-1:EBB], EBB'(i)}] <= ee_buf[i]; // R15
      end
    end
    if (wr_start && cmd_q == CMD_CHIP_ERASE) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_mem[i] <= 16'hFFFF;
      end
      if (hfuse_q[HFB_EE_PRESERVE]) begin // R11
        for (int i = 0; i < EE_BYTES; i++) begin
          ee_mem[i] <= 8'hFF;
        end
      end
    end
  end

  ppp_busy_timer #(
    .CYCLES(BUSY_CYCLES)
  ) u_busy (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(wr_start),
    .ready_q(ready)
  );
  assign ready_busy_out = ready; // R17 R26
endmodule : ppp_program_port

// [tb/ppp_monitor.sv]
`timescale 1ns/10ps
module ppp_monitor
  import ppp_pkg::*;
#(
  parameter int BUSY_CYCLES = PROG_CYCLES,
  parameter logic [7:0] CAL_BYTE = CAL_BYTE_RESET
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hv_reset_in,
  input wire logic crystal_in_strobe,
  input wire logic strobe_action_sel_0,
  input wire logic strobe_action_sel_1,
  input wire logic byte_select_lo,
  input wire logic page_load_strobe,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_out,
  input wire logic prog_active,
  input wire logic [7:0] high_fuse_latched,
  input wire logic [7:0] low_fuse_latched,
  input wire logic int_rc_osc_sel,
  input wire logic [7:0] osc_calibration_reg
);
  localparam int BUSY_WAIT = BUSY_CYCLES + 8;
  logic [7:0] cmd_d, cmd_q, low_d, low_q;
  logic xs_q, wr_cmd;
  // shadow of the loaded command so write strobes can be judged
  always_comb begin
    cmd_d = cmd_q;
    if (crystal_in_strobe && !xs_q && prog_active &&
        {strobe_action_sel_1, strobe_action_sel_0} == ACT_CMD) begin
      cmd_d = data_in;
    end
    low_d = ready_busy_out ? 8'h00 : low_q + 8'h01;
  end
  always_ff @(posedge mclk) begin
    cmd_q <= sys_rst ? CMD_NOP : cmd_d;
    low_q <= sys_rst ? 8'h00 : low_d;
    xs_q <= crystal_in_strobe;
  end
  assign wr_cmd = cmd_q inside {CMD_CHIP_ERASE, CMD_WRITE_FUSE, CMD_WRITE_LOCK,
    CMD_WRITE_FLASH, CMD_WRITE_EEPROM};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_rst;
    disable iff (1'b0) sys_rst |=> ready_busy_out && !prog_active && !data_oe &&
      data_out == 8'hFF && osc_calibration_reg == CAL_BYTE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  property p_oe;
    data_oe |-> prog_active && !$past(oe_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven without enable");
  property p_entry;
    $rose(hv_reset_in) && {page_load_strobe, strobe_action_sel_1, strobe_action_sel_0,
      byte_select_lo} == 4'h0 |=> prog_active;
  endproperty
  a_entry: assert property (p_entry) else $error("mode not entered");
  property p_exit;
    !hv_reset_in |=> !prog_active;
  endproperty
  a_exit: assert property (p_exit) else $error("mode not left");
  property p_hold;
    prog_active && $past(prog_active) |-> $stable(low_fuse_latched) &&
      $stable(high_fuse_latched);
  endproperty
  a_hold: assert property (p_hold) else $error("latched fuse moved in mode");
  property p_rc;
    $stable(low_fuse_latched) |-> int_rc_osc_sel == (low_fuse_latched[3:0] == CKSEL_INT_RC);
  endproperty
  a_rc: assert property (p_rc) else $error("rc select wrong");
  property p_wr;
    $fell(wr_n) && prog_active && ready_busy_out && wr_cmd |=> !ready_busy_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write not started");
  property p_ign;
    $fell(wr_n) && !wr_cmd && ready_busy_out |=> ready_busy_out;
  endproperty
  a_ign: assert property (p_ign) else $error("read command went busy");
  property p_busy;
    $rose(ready_busy_out) && !$past(sys_rst) |-> low_q >= BUSY_CYCLES;
  endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_bound;
    $fell(ready_busy_out) |-> ##[1:BUSY_WAIT] ready_busy_out;
  endproperty
  a_bound: assert property (p_bound) else $error("busy never ends");
endmodule : ppp_monitor

// [tb/ppp_programmer_model.sv]
`timescale 1ns/10ps
module ppp_programmer_model (
  input wire logic mclk,
  input wire logic ready_busy_out,
  input wire logic [7:0] bus,
  output logic hv_reset_in,
  output logic crystal_in_strobe,
  output logic strobe_action_sel_0,
  output logic strobe_action_sel_1,
  output logic byte_select_lo,
  output logic byte_select_hi,
  output logic page_load_strobe,
  output logic wr_n,
  output logic oe_n,
  output logic [7:0] prog_data
);
  initial begin
    {hv_reset_in, crystal_in_strobe, strobe_action_sel_1, strobe_action_sel_0} = 4'h0;
    {byte_select_hi, byte_select_lo, page_load_strobe} = 3'h0;
    {wr_n, oe_n} = 2'h3;
    prog_data = 8'h00;
  end
  task automatic hold();
    repeat (7) @(posedge mclk);
  endtask : hold
  task automatic enter();
    repeat (12) begin
      crystal_in_strobe <= ~crystal_in_strobe;
      hold();
    end
    {page_load_strobe, strobe_action_sel_1, strobe_action_sel_0, byte_select_lo} <= 4'h0;
    hold();
    hv_reset_in <= 1'b1;
    repeat (1250) @(posedge mclk);
  endtask : enter
  task automatic leave();
    hv_reset_in <= 1'b0;
    hold();
  endtask : leave
  task automatic xload(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] v);
    {strobe_action_sel_1, strobe_action_sel_0} <= act;
    {byte_select_hi, byte_select_lo} <= bs;
    prog_data <= v;
    crystal_in_strobe <= 1'b1;
    hold();
    crystal_in_strobe <= 1'b0;
    hold();
  endtask : xload
  task automatic pload();
    page_load_strobe <= 1'b1;
    hold();
    page_load_strobe <= 1'b0;
    hold();
  endtask : pload
  task automatic wpulse(input logic [1:0] bs);
    {byte_select_hi, byte_select_lo} <= bs;
    wr_n <= 1'b0;
    hold();
    wr_n <= 1'b1;
    for (int i = 0; i < 200 && ready_busy_out !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
  endtask : wpulse
  task automatic rd(input logic [1:0] bs, output logic [7:0] v);
    {byte_select_hi, byte_select_lo} <= bs;
    oe_n <= 1'b0;
    // released bus: no stale byte may pass for the device's answer
    prog_data <= ~prog_data;
    repeat (3) @(posedge mclk);
    v = bus;
    oe_n <= 1'b1;
    @(posedge mclk);
  endtask : rd
endmodule : ppp_programmer_model

// [tb/ppp_program_port_tb_top.sv]
`timescale 1ns/10ps
module ppp_program_port_tb_top;
  import ppp_pkg::*;
  logic mclk, sys_rst, serial_prog_mode, hv_reset_in, crystal_in_strobe;
  logic strobe_action_sel_0, strobe_action_sel_1, byte_select_lo, byte_select_hi;
  logic page_load_strobe, wr_n, oe_n, data_oe, ready_busy_out, prog_active;
  logic eeprom_preserve_active, int_rc_osc_sel;
  logic [7:0] data_in, data_out, prog_data, ext_fuse_latched, high_fuse_latched;
  logic [7:0] low_fuse_latched, osc_calibration_reg, rv;
  int errors, checks_done;
  assign data_in = data_oe ? data_out : prog_data;
  // short busy time keeps the run brief
  ppp_program_port #(.BUSY_CYCLES(4)) dut (.*);
  ppp_programmer_model prog (.bus(data_in), .*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [1:0] bs, input logic [7:0] exp);
    prog.rd(bs, rv);
    check(rv, exp);
  endtask : rdc
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic t_reset();
    check(osc_calibration_reg, CAL_BYTE_RESET);
    check(ready_busy_out, 1'b1);
    check(ext_fuse_latched, 8'hFF);
    check(high_fuse_latched, 8'h99);
    check(low_fuse_latched, 8'h62);
    check(int_rc_osc_sel, 1'b1);
  endtask : t_reset
  task automatic t_read();
    logic [7:0] exp [4] = '{8'h62, 8'hFF, 8'hFF, 8'h99};
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
    for (int b = 0; b < 4; b++) rdc(2'(b), exp[b]);
    serial_prog_mode <= 1'b1;
    rdc(BSEL_FHIGH, 8'hB9);
    serial_prog_mode <= 1'b0;
  endtask : t_read
  task automatic t_sig();
    logic [7:0] sig [3] = '{8'hA5, 8'h5A, 8'h3C};
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_SIG);
    for (int a = 0; a < 3; a++) begin
      prog.xload(ACT_ADDR, BSEL_LOW, 8'(a));
      rdc(BSEL_LOW, sig[a]);
    end
    prog.xload(ACT_ADDR, BSEL_LOW, 8'h00);
    rdc(BSEL_HIGH, CAL_BYTE_RESET);
  endtask : t_sig
  task automatic t_fuse();
    prog.xload(ACT_CMD, BSEL_LOW, CMD_WRITE_FUSE);
    prog.xload(ACT_DATA, BSEL_LOW, 8'h00);
    prog.wpulse(BSEL_LOW);
    prog.wpulse(BSEL_EXT);
    prog.xload(ACT_DATA, BSEL_LOW, 8'h91);
    prog.wpulse(BSEL_HIGH);
    check(eeprom_preserve_active, 1'b1);
    check(low_fuse_latched, 8'h62);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
    rdc(BSEL_LOW, 8'h00);
    rdc(BSEL_EXT, 8'hF8);
    rdc(BSEL_FHIGH, 8'h91);
    prog.leave();
    check(low_fuse_latched, 8'h00);
    check(int_rc_osc_sel, 1'b0);
    prog.enter();
  endtask : t_fuse
  task automatic t_lock();
    prog.xload(ACT_CMD, BSEL_LOW, CMD_WRITE_LOCK);
    prog.xload(ACT_DATA, BSEL_LOW, 8'hFE);
    prog.wpulse(BSEL_LOW);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_WRITE_FUSE);
    prog.xload(ACT_DATA, BSEL_LOW, 8'hFF);
    prog.wpulse(BSEL_LOW);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
    prog.wpulse(BSEL_LOW);
    rdc(BSEL_LOW, 8'h00);
    rdc(BSEL_HIGH, 8'hFE);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_CHIP_ERASE);
    prog.wpulse(BSEL_LOW);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
    rdc(BSEL_FHIGH, 8'h91);
    rdc(BSEL_HIGH, 8'hFF);
  endtask : t_lock
  task automatic t_flash();
    prog.xload(ACT_CMD, BSEL_LOW, CMD_WRITE_FLASH);
    prog.xload(ACT_ADDR, BSEL_LOW, 8'h85);
    prog.xload(ACT_ADDR, BSEL_HIGH, 8'h01);
    prog.xload(ACT_ADDR, BSEL_FHIGH, 8'h00);
    prog.xload(ACT_DATA, BSEL_LOW, 8'h34);
    prog.xload(ACT_DATA, BSEL_HIGH, 8'h12);
    prog.xload(ACT_DATA, BSEL_EXT, 8'hEE);
    prog.pload();
    prog.wpulse(BSEL_LOW);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_FLASH);
    rdc(BSEL_LOW, 8'h34);
    rdc(BSEL_HIGH, 8'h12);
  endtask : t_flash
  task automatic t_ee();
    prog.xload(ACT_CMD, BSEL_LOW, CMD_WRITE_EEPROM);
    prog.xload(ACT_ADDR, BSEL_HIGH, 8'h02);
    prog.xload(ACT_ADDR, BSEL_LOW, 8'h0B);
    prog.xload(ACT_DATA, BSEL_LOW, 8'h5C);
    prog.pload();
    prog.wpulse(BSEL_LOW);
    prog.xload(ACT_CMD, BSEL_LOW, CMD_READ_EEPROM);
    rdc(BSEL_LOW, 8'h5C);
  endtask : t_ee
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    serial_prog_mode = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    prog.enter();
    t_read();
    t_sig();
    t_fuse();
    t_lock();
    t_flash();
    t_ee();
    close_out();
  end
endmodule : ppp_program_port_tb_top
bind ppp_program_port ppp_monitor #(.BUSY_CYCLES(BUSY_CYCLES), .CAL_BYTE(CAL_BYTE)) u_mon (.*);
